//--- ext_mem.sv
// Behavioural memory and I/O on the external multiplexed bus
`timescale 1ns/1ns
`include "mode_map_consts.vh"
module ext_mem (
    // Clock
    input  wire       ref_clk,
    // Bus outputs of the block
    input  wire [7:0] port_b_out_r,
    input  wire       port_b_oe_r,
    input  wire [7:0] port_c_out_r,
    input  wire       port_c_oe_r,
    input  wire       address_strobe_r,
    input  wire       rw_out_r,
    input  wire       ctl_oe_r,
    // Resolved port C level
    output wire [7:0] port_c_in
);
    reg  [7:0]  mem [0:65535];
    reg  [15:0] addr_r = 16'h0000;
    reg  [2:0]  ph_r   = 3'h0;
    reg  [7:0]  last_r = 8'h00;
    // Board pull-ups hold undriven strobe, direction and high address up
    wire        as_pin = ctl_oe_r ? address_strobe_r : 1'b1;
    wire        rd_pin = ctl_oe_r ? rw_out_r : 1'b1;
    wire [7:0]  hi_pin = port_b_oe_r ? port_b_out_r : 8'hFF;
    wire        drive  = ph_r != 3'h0 && !as_pin && rd_pin && !port_c_oe_r;
    // Released port C shows a changing pattern, not a held value
    assign port_c_in = port_c_oe_r ? port_c_out_r : drive ? mem[addr_r] : ~last_r;
    // Address latched on the strobe, then a fixed data phase
    always @(posedge ref_clk) begin
        last_r <= port_c_in;
        if (as_pin) begin
            addr_r <= {hi_pin, port_c_out_r};
            ph_r   <= `DATA_PHASE_CYCLES;
        end else if (ph_r != 3'h0) begin
            ph_r <= ph_r - 3'h1;
            if (!rd_pin && port_c_oe_r)
                mem[addr_r] <= port_c_out_r;
        end
    end
endmodule

//--- mode_map.v
// Operating mode latch, memory decode, vector placement and external bus
`timescale 1ns/1ns
`include "mode_map_consts.vh"

module mode_map #(
    parameter BIT_CYCLES = `BIT_CYCLES_DEFAULT
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        nrst,
    // Mode and strap pins
    input  wire        mode_select_pin_a,
    input  wire        mode_select_pin_b,
    input  wire        irq_pin_n,
    input  wire        vpp_present,
    input  wire        rx_line,
    // Software control
    input  wire        mode_wr,
    input  wire        mode_wr_special,
    input  wire        mode_wr_a,
    input  wire        regbase_wr,
    input  wire [3:0]  regbase_val,
    input  wire        jump_ram_cmd,
    input  wire        jump_prog_cmd,
    // Processor access
    input  wire        cpu_req,
    input  wire        cpu_wr,
    input  wire [15:0] cpu_addr,
    input  wire [7:0]  cpu_wdata,
    input  wire        vec_req,
    input  wire [4:0]  vec_idx,
    // Mode state
    output reg         special_mode_bit_r,
    output reg         mode_a_bit_r,
    output reg         prog_high_r,
    output reg         test_bits_en_r,
    output reg         prog_start_r,
    output reg  [3:0]  regbase_r,
    // Decode results
    output reg         sel_regs_r,
    output reg         sel_ram_r,
    output reg         sel_loader_r,
    output reg         sel_prog_r,
    output reg         sel_ext_r,
    output reg  [15:0] vec_addr_r,
    output reg         vec_ext_r,
    output reg         vec_valid_r,
    output reg  [15:0] jump_addr_r,
    output reg         jump_go_r,
    // External multiplexed bus
    output reg  [7:0]  port_b_out_r,
    output reg         port_b_oe_r,
    output reg  [7:0]  port_c_out_r,
    output reg         port_c_oe_r,
    input  wire [7:0]  port_c_in,
    output reg         address_strobe_r,
    output reg         rw_out_r,
    output reg         ctl_oe_r,
    output reg  [7:0]  ext_rdata_r,
    output reg         ext_done_r,
    output reg         ext_busy_r
);

    localparam ST_IDLE = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam IDLE_CYCLES = BIT_CYCLES * `BITS_PER_CHAR * `IDLE_CHARS;

    // Two-flop synchronisers for the pins
    reg  [4:0] pin_s1_r;
    reg  [4:0] pin_s2_r;
    reg  [7:0] pc_s1_r;
    reg  [7:0] pc_s2_r;
    wire [4:0] pin_raw = {rx_line, vpp_present, irq_pin_n, mode_select_pin_b,
                          mode_select_pin_a};

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= 5'h1F;
            pin_s2_r <= 5'h1F;
            pc_s1_r  <= 8'h00;
            pc_s2_r  <= 8'h00;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pc_s1_r  <= port_c_in;
            pc_s2_r  <= pc_s1_r;
        end
    end

    wire pa_s   = pin_s2_r[0];
    wire pb_s   = pin_s2_r[1];
    wire irqn_s = pin_s2_r[2];
    wire vpp_s  = pin_s2_r[3];
    wire rx_s   = pin_s2_r[4];

    // Capture point after release
    reg  [1:0] cap_cnt_r;
    reg        captured_r;
    wire       cap_now = !captured_r && (cap_cnt_r == `CAPTURE_EDGE);
    wire [1:0] mode = {special_mode_bit_r, mode_a_bit_r};

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cap_cnt_r  <= 2'h0;
            captured_r <= 1'b0;
        end else begin
            if (!captured_r && cap_cnt_r != `CAPTURE_EDGE) begin
                cap_cnt_r <= cap_cnt_r + 2'h1;
            end
            if (cap_now) begin
                captured_r <= 1'b1;
            end
        end
    end

    // Mode bits, program location, register block base
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            special_mode_bit_r <= 1'b0;
            mode_a_bit_r       <= 1'b0;
            prog_high_r        <= 1'b1;
            prog_start_r       <= 1'b0;
            regbase_r          <= `REG_BASE_RESET;
        end else if (cap_now) begin
            special_mode_bit_r <= ~pb_s;
            mode_a_bit_r       <= pa_s;
            prog_high_r        <= ~pa_s;
            prog_start_r       <= ~pb_s & ~pa_s & ~irqn_s & vpp_s;
        end else if (captured_r) begin
            // Pins no longer looked at after capture
            if (mode_wr) begin
                if (special_mode_bit_r) begin
                    special_mode_bit_r <= mode_wr_special;
                    mode_a_bit_r       <= mode_wr_a;
                end else if (mode_wr_a) begin
                    mode_a_bit_r <= 1'b1;
                end
            end
            if (regbase_wr) begin
                regbase_r <= regbase_val;
            end
        end
    end

    // Test control bits open only in test mode
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            test_bits_en_r <= 1'b0;
        end else begin
            test_bits_en_r <= (mode == `MODE_TEST);
        end
    end

    // Address decode, register block first
    wire hit_regs   = (cpu_addr[15:12] == regbase_r) && (cpu_addr[11:6] == 6'h00);
    wire hit_ram    = (cpu_addr <= `RAM_END);
    wire hit_loader = (mode == `MODE_BOOT) && (cpu_addr[15:8] == `LOADER_PAGE);
    wire hit_prog   = prog_high_r ? (cpu_addr[15:12] == `PROG_HIGH_PAGE)
                                  : (cpu_addr[15:12] == `PROG_LOW_PAGE);
    wire hit_ext    = mode_a_bit_r && !hit_regs && !hit_ram && !hit_loader
                      && !hit_prog;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sel_regs_r   <= 1'b0;
            sel_ram_r    <= 1'b0;
            sel_loader_r <= 1'b0;
            sel_prog_r   <= 1'b0;
            sel_ext_r    <= 1'b0;
        end else begin
            sel_regs_r   <= cpu_req && hit_regs;
            sel_ram_r    <= cpu_req && !hit_regs && hit_ram;
            sel_loader_r <= cpu_req && !hit_regs && !hit_ram && hit_loader;
            sel_prog_r   <= cpu_req && !hit_regs && !hit_ram && !hit_loader && hit_prog;
            sel_ext_r    <= cpu_req && hit_ext;
        end
    end

    // Vector placement, one cycle behind the slot lookup
    wire [15:0] rom_slot;
    reg         vec_pend_r;
    reg  [4:0]  vec_idx_r;
    wire [15:0] vec_back = {10'h000, `VEC_RESET_IDX - vec_idx_r, 1'b0};

    vector_rom u_rom (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .idx     (vec_idx),
        .slot_r  (rom_slot)
    );

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            vec_pend_r  <= 1'b0;
            vec_idx_r   <= 5'h00;
            vec_addr_r  <= 16'h0000;
            vec_ext_r   <= 1'b0;
            vec_valid_r <= 1'b0;
        end else begin
            vec_pend_r  <= vec_req && (vec_idx < `VEC_COUNT);
            vec_idx_r   <= vec_idx;
            vec_valid_r <= vec_pend_r;
            if (vec_pend_r) begin
                case (mode)
                    `MODE_BOOT: begin
                        vec_addr_r <= rom_slot;
                        vec_ext_r  <= 1'b0;
                    end
                    `MODE_TEST: begin
                        vec_addr_r <= `VEC_TEST_TOP - vec_back;
                        vec_ext_r  <= 1'b1;
                    end
                    default: begin
                        vec_addr_r <= `VEC_NORM_TOP - vec_back;
                        vec_ext_r  <= mode_a_bit_r && !prog_high_r;
                    end
                endcase
            end
        end
    end

    // Loader idle-line detector and immediate jumps
    reg [31:0] idle_cnt_r;
    reg        rx_seen_r;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt_r  <= 32'h0000_0000;
            rx_seen_r   <= 1'b0;
            jump_go_r   <= 1'b0;
            jump_addr_r <= `JUMP_RAM_ADDR;
        end else begin
            jump_go_r <= 1'b0;
            if (mode != `MODE_BOOT || !rx_s) begin
                idle_cnt_r <= 32'h0000_0000;
                rx_seen_r  <= (mode == `MODE_BOOT) ? 1'b1 : 1'b0;
            end else if (rx_seen_r) begin
                if (idle_cnt_r == IDLE_CYCLES - 1) begin
                    rx_seen_r   <= 1'b0;
                    jump_go_r   <= 1'b1;
                    jump_addr_r <= `JUMP_RAM_ADDR;
                end else begin
                    idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
                end
            end
            if (mode == `MODE_BOOT && jump_ram_cmd) begin
                jump_go_r   <= 1'b1;
                jump_addr_r <= `JUMP_RAM_ADDR;
            end else if (mode == `MODE_BOOT && jump_prog_cmd) begin
                jump_go_r   <= 1'b1;
                jump_addr_r <= `JUMP_PROG_ADDR;
            end
        end
    end

    // Multiplexed external bus cycle
    reg [1:0]  bus_st_r;
    reg [2:0]  phase_cnt_r;
    reg [15:0] bus_addr_r;
    reg [7:0]  bus_wdata_r;
    reg        bus_wr_r;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_st_r         <= ST_IDLE;
            phase_cnt_r      <= 3'h0;
            bus_addr_r       <= 16'h0000;
            bus_wdata_r      <= 8'h00;
            bus_wr_r         <= 1'b0;
            port_b_out_r     <= 8'hFF;
            port_b_oe_r      <= 1'b0;
            port_c_out_r     <= 8'h00;
            port_c_oe_r      <= 1'b0;
            address_strobe_r <= 1'b0;
            rw_out_r         <= 1'b1;
            ctl_oe_r         <= 1'b0;
            ext_rdata_r      <= 8'h00;
            ext_done_r       <= 1'b0;
            ext_busy_r       <= 1'b0;
        end else begin
            ext_done_r  <= 1'b0;
            ctl_oe_r    <= mode_a_bit_r;
            port_b_oe_r <= mode_a_bit_r;
            case (bus_st_r)
                ST_IDLE: begin
                    port_c_oe_r      <= 1'b0;
                    address_strobe_r <= 1'b0;
                    rw_out_r         <= 1'b1;
                    if (cpu_req && hit_ext) begin
                        bus_addr_r       <= cpu_addr;
                        bus_wdata_r      <= cpu_wdata;
                        bus_wr_r         <= cpu_wr;
                        port_b_out_r     <= cpu_addr[15:8];
                        port_c_out_r     <= cpu_addr[7:0];
                        port_c_oe_r      <= 1'b1;
                        address_strobe_r <= 1'b1;
                        rw_out_r         <= ~cpu_wr;
                        ext_busy_r       <= 1'b1;
                        bus_st_r         <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    address_strobe_r <= 1'b0;
                    port_c_out_r     <= bus_wdata_r;
                    port_c_oe_r      <= bus_wr_r;
                    phase_cnt_r      <= 3'h1;
                    bus_st_r         <= ST_DATA;
                end
                ST_DATA: begin
                    if (phase_cnt_r == `DATA_PHASE_CYCLES) begin
                        ext_rdata_r <= bus_wr_r ? bus_wdata_r : pc_s2_r;
                        ext_done_r  <= 1'b1;
                        ext_busy_r  <= 1'b0;
                        port_c_oe_r <= 1'b0;
                        rw_out_r    <= 1'b1;
                        bus_st_r    <= ST_IDLE;
                    end else begin
                        phase_cnt_r <= phase_cnt_r + 3'h1;
                    end
                end
                default: begin
                    bus_st_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

//--- mode_map_consts.vh
// Constants for the operating mode select and memory map block
`ifndef MODE_MAP_CONSTS_VH
`define MODE_MAP_CONSTS_VH

// Mode codes {special_mode_bit, mode_a_bit}
`define MODE_SINGLE        2'h0
`define MODE_EXPANDED      2'h1
`define MODE_BOOT          2'h2
`define MODE_TEST          2'h3

// Clock edges counted after reset release; the mode pins are captured on the edge after that count
`define CAPTURE_EDGE       2'h3

// Memory map
`define PROG_HIGH_PAGE     4'hF
`define PROG_LOW_PAGE      4'h7
`define LOADER_PAGE        8'hBF
`define REG_BASE_RESET     4'h0
`define RAM_END            16'h00FF
`define JUMP_RAM_ADDR      16'h0000
`define JUMP_PROG_ADDR     16'hF000

// Vector table: 21 vectors, index 20 is reset, two bytes each
`define VEC_COUNT          5'h15
`define VEC_RESET_IDX      5'h14
`define VEC_NORM_TOP       16'hFFFE
`define VEC_TEST_TOP       16'hBFFE
`define LOADER_ENTRY       16'hBF00

// External bus: cycles of the data phase before read data is taken
`define DATA_PHASE_CYCLES  3'h4

// Serial idle detection: bits per character and characters of idle line
`define BITS_PER_CHAR      4'hA
`define IDLE_CHARS         4'h4
`define BIT_CYCLES_DEFAULT 3200

`endif

//--- mode_map_sva.sv
// Port-level checks for the mode select and memory map block
`timescale 1ns/1ns
module mode_map_sva (
    // Clock and reset
    input wire        ref_clk,
    input wire        nrst,
    // Requests
    input wire        mode_wr,
    input wire        mode_wr_a,
    input wire        jump_ram_cmd,
    input wire        jump_prog_cmd,
    input wire        cpu_req,
    input wire        cpu_wr,
    input wire [15:0] cpu_addr,
    input wire [7:0]  cpu_wdata,
    input wire        vec_req,
    input wire [4:0]  vec_idx,
    // Results
    input wire        special_mode_bit_r,
    input wire        mode_a_bit_r,
    input wire        prog_high_r,
    input wire        test_bits_en_r,
    input wire [3:0]  regbase_r,
    input wire        sel_ext_r,
    input wire [15:0] vec_addr_r,
    input wire        vec_ext_r,
    input wire        vec_valid_r,
    input wire [15:0] jump_addr_r,
    input wire        jump_go_r,
    // External bus
    input wire [7:0]  port_b_out_r,
    input wire        port_b_oe_r,
    input wire [7:0]  port_c_out_r,
    input wire        port_c_oe_r,
    input wire        address_strobe_r,
    input wire        rw_out_r,
    input wire        ctl_oe_r,
    input wire        ext_done_r,
    input wire        ext_busy_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    reg  [2:0] up_cnt_r;
    wire       boot = special_mode_bit_r && !mode_a_bit_r;
    wire       test = special_mode_bit_r && mode_a_bit_r;
    // Edges since reset release, saturating past the capture edge
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            up_cnt_r <= 3'h0;
        else if (up_cnt_r != 3'h7)
            up_cnt_r <= up_cnt_r + 3'h1;
    end
    // Bus cycle steps
    sequence s_data;
        (!address_strobe_r && ext_busy_r) [*4];
    endsequence
    property p_no_ext;
        !mode_a_bit_r && !$past(mode_a_bit_r) |-> !(ctl_oe_r || port_b_oe_r || port_c_oe_r);
    endproperty
    property p_ext_sel;
        cpu_req && cpu_addr[15:13] == 3'h4 && regbase_r[3:1] != 3'h4
            |=> sel_ext_r == $past(mode_a_bit_r);
    endproperty
    property p_bus_walk;
        $rose(address_strobe_r) |=> s_data ##1 (ext_done_r && !ext_busy_r);
    endproperty
    property p_addr_phase;
        address_strobe_r |-> ctl_oe_r && port_b_oe_r && port_c_oe_r
            && {port_b_out_r, port_c_out_r} == $past(cpu_addr) && rw_out_r == !$past(cpu_wr);
    endproperty
    property p_data_phase;
        address_strobe_r |=> port_c_oe_r == !$past(rw_out_r)
            && (rw_out_r || port_c_out_r == $past(cpu_wdata, 2));
    endproperty
    property p_vec_time;
        vec_req && vec_idx <= 5'h14 |-> ##2 vec_valid_r;
    endproperty
    property p_vec_boot;
        vec_req && vec_idx == 5'h14 && boot |-> ##2 (vec_addr_r == 16'hBF00 && !vec_ext_r);
    endproperty
    property p_vec_test;
        vec_req && vec_idx <= 5'h14 && test |-> ##2 (vec_ext_r && vec_addr_r[15:6] == 10'h2FF);
    endproperty
    property p_test_bits;
        test_bits_en_r |-> test || $past(test);
    endproperty
    property p_pins_held;
        up_cnt_r == 3'h7 && !$past(mode_wr)
            |-> $stable(special_mode_bit_r) && $stable(mode_a_bit_r);
    endproperty
    property p_jump;
        boot && (jump_ram_cmd || jump_prog_cmd) |=> jump_go_r
            && jump_addr_r == ($past(jump_ram_cmd) ? 16'h0000 : 16'hF000);
    endproperty
    property p_sw_expand;
        mode_wr && mode_wr_a && !special_mode_bit_r |=> mode_a_bit_r && $stable(prog_high_r);
    endproperty
    a_no_ext: assert property (p_no_ext) else $error("bus driven outside expanded modes");
    a_ext_sel: assert property (p_ext_sel) else $error("external select wrong");
    a_bus_walk: assert property (p_bus_walk) else $error("bus cycle length wrong");
    a_addr_phase: assert property (p_addr_phase) else $error("address phase wrong");
    a_data_phase: assert property (p_data_phase) else $error("data phase wrong");
    a_vec_time: assert property (p_vec_time) else $error("vector answer late");
    a_vec_boot: assert property (p_vec_boot) else $error("loader reset vector wrong");
    a_vec_test: assert property (p_vec_test) else $error("test vector wrong");
    a_test_bits: assert property (p_test_bits) else $error("test bits outside test");
    a_pins_held: assert property (p_pins_held) else $error("mode bits moved");
    a_jump: assert property (p_jump) else $error("loader jump wrong");
    a_sw_expand: assert property (p_sw_expand) else $error("switch to expanded wrong");
endmodule

//--- mode_map_tb.sv
// Self-checking testbench for the mode select and memory map block
`timescale 1ns/1ns
module mode_map_tb;
    localparam logic [3:0] PIN_A = 4'hA;
    localparam logic [3:0] PIN_B = 4'h3;
    logic ref_clk, nrst, mode_select_pin_a, mode_select_pin_b, irq_pin_n, vpp_present;
    logic rx_line, mode_wr, mode_wr_special, mode_wr_a, regbase_wr, jump_ram_cmd;
    logic jump_prog_cmd, cpu_req, cpu_wr, vec_req;
    logic [3:0] regbase_val;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_wdata;
    logic [4:0] vec_idx;
    wire special_mode_bit_r, mode_a_bit_r, prog_high_r, test_bits_en_r, prog_start_r;
    wire sel_regs_r, sel_ram_r, sel_loader_r, sel_prog_r, sel_ext_r, vec_ext_r;
    wire vec_valid_r, jump_go_r, port_b_oe_r, port_c_oe_r, address_strobe_r;
    wire rw_out_r, ctl_oe_r, ext_done_r, ext_busy_r;
    wire [3:0] regbase_r;
    wire [15:0] vec_addr_r, jump_addr_r;
    wire [7:0] port_b_out_r, port_c_out_r, port_c_in, ext_rdata_r;
    int miscompares, tests_run, cycles;

    mode_map #(.BIT_CYCLES(2)) uut (.*);
    ext_mem mem (.*);

    // Clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic mode_is(input logic [1:0] e);
        chk({14'h0000, special_mode_bit_r, mode_a_bit_r}, {14'h0000, e});
    endtask
    task automatic boot_up(input logic a, input logic b, input logic irq, input logic vpp);
        nrst = 1'b0;
        {mode_select_pin_a, mode_select_pin_b, irq_pin_n, vpp_present} = {a, b, irq, vpp};
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic access(input logic [15:0] a, input logic wr, input logic [7:0] d);
        {cpu_addr, cpu_wr, cpu_wdata, cpu_req} = {a, wr, d, 1'b1};
        @(negedge ref_clk);
        cpu_req = 1'b0;
    endtask
    task automatic sel_chk(input logic [15:0] a, input logic [4:0] e);
        access(a, 1'b0, 8'h00);
        chk({11'h000, sel_regs_r, sel_ram_r, sel_loader_r, sel_prog_r, sel_ext_r}, {11'h000, e});
        // Let an edge pass so the next request is not raised as this one drops
        @(negedge ref_clk);
    endtask
    task automatic bus(input logic [15:0] a, input logic wr, input logic [7:0] d);
        int i;
        access(a, wr, d);
        for (i = 0; i < 10 && ext_done_r !== 1'b1; i++)
            @(negedge ref_clk);
        chk_bit(ext_done_r, 1'b1);
    endtask
    task automatic vec_chk(input logic [4:0] idx, input logic [15:0] ea, input logic ee);
        {vec_idx, vec_req} = {idx, 1'b1};
        @(negedge ref_clk);
        vec_req = 1'b0;
        @(negedge ref_clk);
        chk_bit(vec_valid_r, 1'b1);
        chk(vec_addr_r, ea);
        chk_bit(vec_ext_r, ee);
    endtask
    task automatic mode_write(input logic s, input logic a);
        {mode_wr_special, mode_wr_a, mode_wr} = {s, a, 1'b1};
        @(negedge ref_clk);
        mode_wr = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic jump(input logic r, input logic p, input logic [15:0] ea);
        {jump_ram_cmd, jump_prog_cmd} = {r, p};
        @(negedge ref_clk);
        {jump_ram_cmd, jump_prog_cmd} = 2'h0;
        chk_bit(jump_go_r, 1'b1);
        chk(jump_addr_r, ea);
        @(negedge ref_clk);
    endtask

    // Main sequence
    initial begin
        int m;
        int n;
        nrst = 1'b0;
        {mode_select_pin_a, mode_select_pin_b, irq_pin_n, vpp_present, rx_line} = 5'h1D;
        {mode_wr, mode_wr_special, mode_wr_a, regbase_wr, jump_ram_cmd, jump_prog_cmd} = 6'h00;
        {cpu_req, cpu_wr, vec_req, vec_idx, regbase_val} = 12'h000;
        {cpu_addr, cpu_wdata} = 24'h000000;
        @(negedge ref_clk);
        // Each pin code, then decode and vectors in that mode
        for (m = 0; m < 4; m++) begin
            boot_up(PIN_A[m], PIN_B[m], 1'b1, 1'b0);
            mode_is(m[1:0]);
            chk_bit(prog_high_r, !PIN_A[m]);
            sel_chk(16'h0010, 5'h10);
            chk_bit(test_bits_en_r, m == 3);
            sel_chk(16'hF000, m[0] ? 5'h01 : 5'h02);
            sel_chk(16'h7000, m[0] ? 5'h02 : 5'h00);
            sel_chk(16'hBF00, m == 2 ? 5'h04 : {4'h0, m[0]});
            vec_chk(5'h14, m == 2 ? 16'hBF00 : m == 3 ? 16'hBFFE : 16'hFFFE, m[0]);
            vec_chk(5'h00, m == 2 ? 16'h00C4 : m == 3 ? 16'hBFD6 : 16'hFFD6, m[0]);
            vec_chk(5'h13, m == 2 ? 16'h00FD : m == 3 ? 16'hBFFC : 16'hFFFC, m[0]);
        end
        // Expanded from reset: back-to-back bus writes and reads
        boot_up(1'b1, 1'b1, 1'b1, 1'b0);
        bus(16'h8123, 1'b1, 8'h5A);
        bus(16'h9001, 1'b1, 8'hA5);
        bus(16'h8123, 1'b0, 8'h00);
        chk({8'h00, ext_rdata_r}, 16'h005A);
        bus(16'h9001, 1'b0, 8'h00);
        chk({8'h00, ext_rdata_r}, 16'h00A5);
        // Register block moved to the 9000 page
        {regbase_val, regbase_wr} = {4'h9, 1'b1};
        @(negedge ref_clk);
        regbase_wr = 1'b0;
        chk({12'h000, regbase_r}, 16'h0009);
        sel_chk(16'h903F, 5'h10);
        sel_chk(16'h9040, 5'h01);
        // Pin changes after capture
        {mode_select_pin_a, mode_select_pin_b} = 2'h0;
        repeat (8) @(negedge ref_clk);
        mode_is(2'h1);
        // Single chip switched to expanded by software
        boot_up(1'b0, 1'b1, 1'b1, 1'b0);
        mode_write(1'b1, 1'b0);
        mode_is(2'h0);
        sel_chk(16'h8123, 5'h00);
        mode_write(1'b0, 1'b1);
        mode_is(2'h1);
        chk_bit(prog_high_r, 1'b1);
        sel_chk(16'hF000, 5'h02);
        bus(16'h8123, 1'b0, 8'h00);
        chk({8'h00, ext_rdata_r}, 16'h005A);
        mode_write(1'b0, 1'b0);
        mode_is(2'h1);
        // Bootstrap: jumps, idle line, mode switching
        boot_up(1'b0, 1'b0, 1'b1, 1'b1);
        @(negedge ref_clk);
        chk_bit(prog_start_r, 1'b0);
        jump(1'b1, 1'b0, 16'h0000);
        jump(1'b0, 1'b1, 16'hF000);
        jump(1'b1, 1'b1, 16'h0000);
        rx_line = 1'b0;
        repeat (2) @(negedge ref_clk);
        rx_line = 1'b1;
        n = 0;
        while (jump_go_r !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        chk_bit(n >= 78 && n <= 86, 1'b1);
        chk(jump_addr_r, 16'h0000);
        mode_write(1'b1, 1'b1);
        mode_is(2'h3);
        chk_bit(test_bits_en_r, 1'b1);
        mode_write(1'b0, 1'b1);
        mode_is(2'h1);
        chk_bit(test_bits_en_r, 1'b0);
        // Programming start with interrupt pin low and voltage present
        boot_up(1'b0, 1'b0, 1'b0, 1'b1);
        @(negedge ref_clk);
        chk_bit(prog_start_r, 1'b1);
        report_and_stop();
    end
endmodule

bind mode_map mode_map_sva chk (.*);

//--- vector_rom.v
// Registered lookup of bootstrap jump-table slots per vector
`timescale 1ns/1ns
`include "mode_map_consts.vh"

module vector_rom (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        nrst,
    // Lookup
    input  wire [4:0]  idx,
    output reg  [15:0] slot_r
);

    reg [15:0] slot_nxt;

    // Jump-table slot for each vector, reset goes to the loader
    always @* begin
        case (idx)
            5'h00:   slot_nxt = 16'h00C4;
            5'h01:   slot_nxt = 16'h00C7;
            5'h02:   slot_nxt = 16'h00CA;
            5'h03:   slot_nxt = 16'h00CD;
            5'h04:   slot_nxt = 16'h00D0;
            5'h05:   slot_nxt = 16'h00D3;
            5'h06:   slot_nxt = 16'h00D6;
            5'h07:   slot_nxt = 16'h00D9;
            5'h08:   slot_nxt = 16'h00DC;
            5'h09:   slot_nxt = 16'h00DF;
            5'h0A:   slot_nxt = 16'h00E3;
            5'h0B:   slot_nxt = 16'h00E5;
            5'h0C:   slot_nxt = 16'h00E8;
            5'h0D:   slot_nxt = 16'h00EB;
            5'h0E:   slot_nxt = 16'h00EE;
            5'h0F:   slot_nxt = 16'h00F1;
            5'h10:   slot_nxt = 16'h00F4;
            5'h11:   slot_nxt = 16'h00F7;
            5'h12:   slot_nxt = 16'h00FA;
            5'h13:   slot_nxt = 16'h00FD;
            default: slot_nxt = `LOADER_ENTRY;
        endcase
    end

    // Read data leaves from a register
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            slot_r <= 16'h0000;
        end else begin
            slot_r <= slot_nxt;
        end
    end

endmodule
